// ===== core/contactor_feedback_monitor.sv
// Safety switch output gate with contactor feedback timing and contour supervision.
// Assumes feedback arrives from a pin and the field/contour inputs are on this clock.
//
// Behaviour
// [RULE1] Contour deviation beyond 200 mm forces outputs off
// [RULE2] Contour check adds to field interruption check
// [RULE3] Contour check only for fields enabling it
// [RULE4] Feedback supervision runs only when enabled
// [RULE5] Feedback must read closed before switching on
// [RULE6] Feedback must open within 500 ms after on
// [RULE7] Feedback must close within 500 ms after off
// [RULE8] Failed feedback check returns outputs off
// [RULE9] Failure shows diagnostic code, enters interlock
// [RULE10] Outside circuit applies 24 V while off
// [RULE11] Outside circuit open while outputs on
// [RULE12] Interlock holds outputs off until recovery
`timescale 1ns/1ps
`default_nettype none
module contactor_feedback_monitor
  import monitor_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = FEEDBACK_WINDOW_CYCLES,
  parameter int unsigned FIELDS        = FIELD_COUNT
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      clock_enable,
  input  wire logic                      feedback_supervision_enable,
  input  wire logic                      contactor_feedback_input,
  input  wire logic                      release_request,
  input  wire logic                      field_interrupted,
  input  wire logic [$clog2(FIELDS)-1:0] active_field,
  input  wire logic [FIELDS-1:0]         field_contour_enable,
  input  wire logic                      contour_sample_valid,
  input  wire logic [DISTANCE_WIDTH-1:0] measured_mm,
  input  wire logic [DISTANCE_WIDTH-1:0] reference_mm,
  input  wire logic                      fault_recover,
  output logic                           safety_switch_output,
  output logic                           fault_interlock,
  output logic [7:0]                     diagnostic_code
);
  // Elaboration check; a field count that is not a power of two would index past the enables
  if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= (1 << TIMER_WIDTH) || FIELDS < 2 ||
      FIELDS != (1 << $clog2(FIELDS))) begin
    $error("contactor_feedback_monitor: unsupported parameter values");
  end

  typedef enum logic [4:0] {
    ST_OFF      = 5'b00001,
    ST_WAIT_OPEN  = 5'b00010,
    ST_ON       = 5'b00100,
    ST_WAIT_CLOSE = 5'b01000,
    ST_FAULT    = 5'b10000
  } state_t;

  state_t                 state_reg;
  logic [TIMER_WIDTH-1:0] timer_reg;
  logic                   feedback_meta_reg;
  logic                   feedback_closed_reg;
  logic                   contour_fault;

  // Pin synchroniser; high means the feedback circuit is closed (24 V present)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      feedback_meta_reg   <= 1'b0;
      feedback_closed_reg <= 1'b0;
    end else if (clock_enable) begin
      feedback_meta_reg   <= contactor_feedback_input;
      feedback_closed_reg <= feedback_meta_reg;
    end
  end

  contour_if #(.W(DISTANCE_WIDTH)) contour_bus ();
  assign contour_bus.sample_valid = contour_sample_valid;
  assign contour_bus.measured_mm  = measured_mm;
  assign contour_bus.reference_mm = reference_mm;
  assign contour_bus.check_enable = field_contour_enable[active_field]; // RULE3
  assign contour_fault = contour_bus.deviation; // RULE1

  contour_check #(.TOLERANCE_MM(CONTOUR_TOLERANCE_MM)) u_contour (
    .clock        (clock),
    .rst_b        (rst_b),
    .clock_enable (clock_enable),
    .port         (contour_bus.checker_end)
  );

  logic demand_off;
  // Either check alone drops the outputs
  assign demand_off = !release_request || field_interrupted || contour_fault; // RULE2

  logic timed_out;
  assign timed_out = (timer_reg >= TIMER_WIDTH'(WINDOW_CYCLES - 1));

  // Sequencer for output switching and feedback timing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= ST_OFF;
      timer_reg       <= '0;
      diagnostic_code <= DIAG_NONE;
    end else if (clock_enable) begin
      case (state_reg)
        ST_OFF: begin
          timer_reg <= '0;
          if (!demand_off) begin
            if (!feedback_supervision_enable) begin // RULE4
              state_reg <= ST_ON;
            end else if (feedback_closed_reg) begin // RULE5
              state_reg <= ST_WAIT_OPEN;
            end
          end
        end
        ST_WAIT_OPEN: begin
          timer_reg <= timer_reg + 1'b1;
          if (!feedback_closed_reg) begin
            state_reg <= demand_off ? ST_WAIT_CLOSE : ST_ON;
            timer_reg <= '0;
          end else if (timed_out) begin // RULE6
            state_reg       <= ST_FAULT; // RULE8
            diagnostic_code <= DIAG_OPEN_LATE; // RULE9
          end
        end
        ST_ON: begin
          timer_reg <= '0;
          if (demand_off) begin
            state_reg <= feedback_supervision_enable ? ST_WAIT_CLOSE : ST_OFF;
          end
        end
        ST_WAIT_CLOSE: begin
          timer_reg <= timer_reg + 1'b1;
          if (feedback_closed_reg) begin
            state_reg <= ST_OFF;
            timer_reg <= '0;
          end else if (timed_out) begin // RULE7
            state_reg       <= ST_FAULT;
            diagnostic_code <= DIAG_CLOSE_LATE; // RULE9
          end
        end
        ST_FAULT: begin
          timer_reg <= '0;
          if (fault_recover) begin // RULE12
            state_reg       <= ST_OFF;
            diagnostic_code <= DIAG_NONE;
          end
        end
        default: begin
          state_reg <= ST_FAULT;
        end
      endcase
    end
  end

  // Outputs registered; switch output on only in states that release the load, interlock on in the fault state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      safety_switch_output <= 1'b0;
      fault_interlock      <= 1'b0;
    end else if (clock_enable) begin
      safety_switch_output <= (state_reg == ST_WAIT_OPEN || state_reg == ST_ON) && !demand_off;
      fault_interlock      <= (state_reg == ST_FAULT);
    end
  end

  property p_fault_holds_off;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_FAULT && clock_enable) |=> !safety_switch_output;
  endproperty
  a_fault_holds_off: assert property (p_fault_holds_off) else $error("output on in fault"); // RULE12

  property p_contour_off;
    @(posedge clock) disable iff (!rst_b)
      (contour_fault && clock_enable) |=> !safety_switch_output;
  endproperty
  a_contour_off: assert property (p_contour_off) else $error("contour deviation kept output on"); // RULE1

  property p_interrupt_off;
    @(posedge clock) disable iff (!rst_b)
      (field_interrupted && clock_enable) |=> !safety_switch_output;
  endproperty
  a_interrupt_off: assert property (p_interrupt_off) else $error("interruption kept output on"); // RULE2

  property p_closed_before_on;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_OFF && clock_enable && feedback_supervision_enable && !feedback_closed_reg)
      |=> state_reg != ST_WAIT_OPEN;
  endproperty
  a_closed_before_on: assert property (p_closed_before_on) else $error("switched on with open feedback"); // RULE5

  property p_open_late;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_WAIT_OPEN && clock_enable && feedback_closed_reg && timed_out)
      |=> (state_reg == ST_FAULT) ##1 fault_interlock;
  endproperty
  a_open_late: assert property (p_open_late) else $error("late opening not faulted"); // RULE6

  property p_close_late;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_WAIT_CLOSE && clock_enable && !feedback_closed_reg && timed_out)
      |=> (state_reg == ST_FAULT) && diagnostic_code == DIAG_CLOSE_LATE;
  endproperty
  a_close_late: assert property (p_close_late) else $error("late closing not faulted"); // RULE7

  property p_fault_diag;
    @(posedge clock) disable iff (!rst_b)
      $rose(fault_interlock) |-> diagnostic_code != DIAG_NONE && !safety_switch_output;
  endproperty
  a_fault_diag: assert property (p_fault_diag) else $error("fault without diagnostic"); // RULE9

  property p_disabled_no_fault;
    @(posedge clock) disable iff (!rst_b)
      (!feedback_supervision_enable && clock_enable && state_reg == ST_OFF) |=> state_reg != ST_WAIT_OPEN;
  endproperty
  a_disabled_no_fault: assert property (p_disabled_no_fault) else $error("supervision ran disabled"); // RULE4

  property p_timer_bound;
    @(posedge clock) disable iff (!rst_b)
      timer_reg <= TIMER_WIDTH'(WINDOW_CYCLES);
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("feedback timer overran"); // RULE6 RULE7

  c_on: cover property (@(posedge clock) disable iff (!rst_b) $rose(safety_switch_output));
  c_cycle: cover property (@(posedge clock) disable iff (!rst_b)
    state_reg == ST_WAIT_CLOSE ##1 state_reg == ST_OFF);
  c_fault: cover property (@(posedge clock) disable iff (!rst_b) $rose(fault_interlock));
  c_contour: cover property (@(posedge clock) disable iff (!rst_b) contour_fault);
endmodule
`default_nettype wire

// ===== core/monitor_pkg.sv
// Constants shared by the contactor feedback monitor and its contour checker.
// Assumes a 100 MHz system clock.
package monitor_pkg;
  localparam int unsigned CLOCK_HZ           = 100_000_000;
  localparam int unsigned FEEDBACK_WINDOW_MS = 500;
  localparam int unsigned FEEDBACK_WINDOW_CYCLES = CLOCK_HZ / 1000 * FEEDBACK_WINDOW_MS;
  localparam int unsigned CONTOUR_TOLERANCE_MM = 200;
  localparam int unsigned DISTANCE_WIDTH     = 16;
  localparam int unsigned FIELD_COUNT        = 4;
  localparam int unsigned TIMER_WIDTH        = 27;
  localparam logic [7:0]  DIAG_NONE          = 8'h00;
  localparam logic [7:0]  DIAG_OPEN_LATE     = 8'h01;
  localparam logic [7:0]  DIAG_CLOSE_LATE    = 8'h02;
  localparam logic [7:0]  DIAG_NOT_CLOSED    = 8'h03;
endpackage

// ===== core/contour_if.sv
// Carries one contour sample between the monitor and the contour checker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface contour_if #(parameter int unsigned W = 16);
  logic         sample_valid;
  logic [W-1:0] measured_mm;
  logic [W-1:0] reference_mm;
  logic         check_enable;
  logic         deviation;
  modport monitor (output sample_valid, output measured_mm, output reference_mm,
                   output check_enable, input deviation);
  modport checker_end (input sample_valid, input measured_mm, input reference_mm,
                       input check_enable, output deviation);
endinterface
`default_nettype wire

// ===== core/contour_check.sv
// Compares a measured contour sample with the stored reference.
// Assumes samples arrive on the system clock, one per valid cycle.
`timescale 1ns/1ps
`default_nettype none
module contour_check
  import monitor_pkg::*;
#(
  parameter int unsigned TOLERANCE_MM = CONTOUR_TOLERANCE_MM
) (
  input  wire logic  clock,
  input  wire logic  rst_b,
  input  wire logic  clock_enable,
  contour_if.checker_end port
);
  localparam int unsigned W = DISTANCE_WIDTH;

  if (TOLERANCE_MM >= (1 << W)) begin
    $error("contour_check: tolerance does not fit the distance width");
  end

  function automatic logic [W-1:0] abs_diff(input logic [W-1:0] a, input logic [W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  logic deviation_reg;
  assign port.deviation = deviation_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      deviation_reg <= 1'b0;
    end else if (clock_enable) begin
      deviation_reg <= port.sample_valid && port.check_enable &&
                       (abs_diff(port.measured_mm, port.reference_mm) > W'(TOLERANCE_MM));
    end
  end
endmodule
`default_nettype wire

// ===== sim/contactor_model.sv
// Behavioural contactor with a positive-guided feedback contact.
// Assumes the monitor output drives the coil; faults are commanded by the bench.
`timescale 1ns/1ps
`default_nettype none
module contactor_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       safety_switch_output,
  input  wire logic [7:0] delay,
  input  wire logic       stuck_closed,
  input  wire logic       stuck_open,
  output logic            contactor_feedback_input
);
  logic [7:0] count_reg;
  logic       contact_reg;

  // Contact follows the coil after a settable delay; closed while the coil is off
  always_ff @(negedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg   <= 8'h00;
      contact_reg <= 1'b1;
    end else if (contact_reg == safety_switch_output) begin
      count_reg <= count_reg + 8'h01;
      if (count_reg >= delay) begin
        contact_reg <= !safety_switch_output;
        count_reg   <= 8'h00;
      end
    end else begin
      count_reg <= 8'h00;
    end
  end

  // Open contact is high impedance and reads low at the pin
  assign contactor_feedback_input = stuck_closed | (!stuck_open & contact_reg);
endmodule
`default_nettype wire

// ===== sim/tb_contactor_feedback_monitor.sv
// Directed bench for the contactor feedback monitor with a contactor model.
// Assumes a 100 MHz clock and a feedback window shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_contactor_feedback_monitor;
  import monitor_pkg::*;
  localparam int unsigned WIN = 20;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        sup_en = 1'b0;
  logic        feedback;
  logic        release_req = 1'b0;
  logic        field_int = 1'b0;
  logic [1:0]  field = 2'h0;
  logic [3:0]  contour_en = 4'h0;
  logic        valid = 1'b0;
  logic [15:0] meas = 16'h0000;
  logic [15:0] refr = 16'h0000;
  logic        recover = 1'b0;
  logic        stuck_c = 1'b0;
  logic        stuck_o = 1'b0;
  logic        out_on;
  logic        interlock;
  logic [7:0]  code;
  logic        hit;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #5 clock = ~clock;

  contactor_feedback_monitor #(.WINDOW_CYCLES(WIN)) dut (
    .clock(clock), .rst_b(rst_b), .clock_enable(ce),
    .feedback_supervision_enable(sup_en), .contactor_feedback_input(feedback),
    .release_request(release_req), .field_interrupted(field_int), .active_field(field),
    .field_contour_enable(contour_en), .contour_sample_valid(valid), .measured_mm(meas),
    .reference_mm(refr), .fault_recover(recover), .safety_switch_output(out_on),
    .fault_interlock(interlock), .diagnostic_code(code));

  contactor_model partner (
    .clock(clock), .rst_b(rst_b), .safety_switch_output(out_on), .delay(8'h03),
    .stuck_closed(stuck_c), .stuck_open(stuck_o), .contactor_feedback_input(feedback));

  task automatic bad(input string msg);
    n_fail++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic wait_out(input logic v, input int lim);
    hit = 1'b0;
    cmp_count++;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clock);
      hit = (out_on === v);
    end
  endtask

  task automatic hold_out(input logic v, input int n);
    hit = 1'b1;
    cmp_count++;
    repeat (n) begin
      @(negedge clock);
      if (out_on !== v) hit = 1'b0;
    end
  endtask

  task automatic recover_pulse;
    recover = 1'b1;
    @(negedge clock);
    recover = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic sample(input logic [15:0] m, input logic [15:0] r);
    valid = 1'b1;
    meas = m;
    refr = r;
    @(negedge clock);
    valid = 1'b0;
  endtask

  task automatic t_plain;
    stuck_o = 1'b1;
    release_req = 1'b1;
    wait_out(1'b1, 4);
    if (!hit) bad("no release without supervision");
    ce = 1'b0;
    release_req = 1'b0;
    hold_out(1'b1, 5);
    if (!hit) bad("state moved while clock enable low");
    ce = 1'b1;
    wait_out(1'b0, 3);
    if (!hit) bad("output stuck on");
    stuck_o = 1'b0;
    repeat (8) @(negedge clock);
  endtask

  task automatic t_cycle;
    sup_en = 1'b1;
    release_req = 1'b1;
    wait_out(1'b1, 8);
    if (!hit) bad("no release with closed feedback");
    hold_out(1'b1, 30);
    if (!hit) bad("dropped though feedback opened");
    release_req = 1'b0;
    hold_out(1'b0, 30);
    if (!hit || interlock !== 1'b0 || code !== DIAG_NONE) bad("fault on good close");
  endtask

  task automatic t_refuse;
    stuck_o = 1'b1;
    // Let the open feedback pass the pin synchroniser before asking for release
    repeat (3) @(negedge clock);
    release_req = 1'b1;
    hold_out(1'b0, 10);
    if (!hit) bad("released with open feedback");
    release_req = 1'b0;
    stuck_o = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic t_open_late;
    stuck_c = 1'b1;
    release_req = 1'b1;
    wait_out(1'b1, 8);
    wait_out(1'b0, WIN + 6);
    if (!hit) bad("output not returned off");
    if (interlock !== 1'b1 || code !== DIAG_OPEN_LATE) bad("open late not flagged");
    stuck_c = 1'b0;
    hold_out(1'b0, 30);
    if (!hit || interlock !== 1'b1) bad("interlock not held");
    recover_pulse();
    wait_out(1'b1, 8);
    if (!hit) bad("no release after recovery");
    release_req = 1'b0;
    repeat (10) @(negedge clock);
  endtask

  task automatic t_close_late;
    release_req = 1'b1;
    wait_out(1'b1, 8);
    repeat (10) @(negedge clock);
    stuck_o = 1'b1;
    release_req = 1'b0;
    repeat (WIN + 6) @(negedge clock);
    if (interlock !== 1'b1 || code !== DIAG_CLOSE_LATE) bad("close late not flagged");
    stuck_o = 1'b0;
    recover_pulse();
    sup_en = 1'b0;
  endtask

  task automatic t_contour;
    contour_en = 4'h2;
    field = 2'h1;
    release_req = 1'b1;
    wait_out(1'b1, 4);
    sample(16'h012c, 16'h0064);
    hold_out(1'b1, 6);
    if (!hit) bad("tripped at tolerance");
    sample(16'h0064, 16'h012d);
    wait_out(1'b0, 4);
    if (!hit) bad("no trip beyond tolerance");
    wait_out(1'b1, 4);
    field = 2'h0;
    sample(16'h012d, 16'h0064);
    hold_out(1'b1, 6);
    if (!hit) bad("tripped on disabled field");
    field_int = 1'b1;
    wait_out(1'b0, 3);
    if (!hit) bad("field violation ignored");
    field_int = 1'b0;
    release_req = 1'b0;
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    bad("timeout");
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge clock);
    cmp_count++;
    if (out_on !== 1'b0 || interlock !== 1'b0 || code !== DIAG_NONE) bad("reset state");
    rst_b = 1'b1;
    t_plain();
    t_cycle();
    t_refuse();
    t_open_late();
    t_close_late();
    t_contour();
    report_and_stop();
  end
endmodule
`default_nettype wire
